// File: src/itb_pkg.sv
// package for the if-then conditional block: encodings, state layout, carriers
`default_nettype none
package itb_pkg;
    localparam int          ITB_MAX_SLOTS   = 4;
    localparam logic [3:0]  ITB_COND_ALWAYS = 4'hE;
    localparam logic [7:0]  ITB_STATE_RST   = 8'h00;
    localparam int          ITB_MASK_LSB    = 0;
    localparam int          ITB_COND_LSB    = 4;

    // instruction classes presented by the decode stage
    typedef enum logic [3:0] {
        ITB_CLS_PLAIN      = 4'h0,
        ITB_CLS_IF_THEN    = 4'h1,
        ITB_CLS_BREAKPOINT = 4'h2,
        ITB_CLS_CMP_BRANCH = 4'h3,
        ITB_CLS_MASK_CHG   = 4'h4,
        ITB_CLS_PC_WRITE   = 4'h5
    } itb_cls_t;

    // instruction as seen by the block
    typedef struct packed {
        itb_cls_t   cls;
        logic [3:0] it_cond;    // base condition of an if-then
        logic [3:0] it_mask;    // selector/length mask of an if-then
    } itb_instr_t;

    // flags used for condition evaluation
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } itb_flags_t;
endpackage : itb_pkg
`default_nettype wire

// File: src/itb_cond_eval.sv
// condition-code evaluator for one four-bit condition against the flags
`timescale 1ns/100ps
`default_nettype none
module itb_cond_eval
    import itb_pkg::*;
(
    input  wire logic [3:0]         cond_i,   // condition code
    input  wire itb_pkg::itb_flags_t flags_i, // current flags
    output logic                    pass_o    // condition holds
);
    logic base;
    // even codes test, odd codes invert the same test; 4'hE and 4'hF both always pass
    always_comb begin
        case (cond_i[3:1])
            3'h0:    base = flags_i.z;
            3'h1:    base = flags_i.c;
            3'h2:    base = flags_i.n;
            3'h3:    base = flags_i.v;
            3'h4:    base = flags_i.c & ~flags_i.z;
            3'h5:    base = (flags_i.n == flags_i.v);
            3'h6:    base = ~flags_i.z & (flags_i.n == flags_i.v);
            default: base = 1'b1;
        endcase
    end
    assign pass_o = (cond_i == 4'hF) ? 1'b1 : (base ^ (cond_i[0] & (cond_i[3:1] != 3'h7)));
endmodule : itb_cond_eval
`default_nettype wire

// File: src/itb_core.sv
// if-then execution-state tracker: slot conditions, breakpoint, exception save/restore
`timescale 1ns/100ps
`default_nettype none
module itb_core
    import itb_pkg::*;
(
    input  wire logic                clock_i,      // core clock, 25 MHz
    input  wire logic                rst_i,        // async reset, active high
    input  wire logic                issue_i,      // one instruction completes this cycle
    input  wire itb_pkg::itb_instr_t instr_i,      // the completing instruction
    input  wire itb_pkg::itb_flags_t flags_i,      // flags for condition checks
    input  wire logic                exc_entry_i,  // exception taken before next instruction
    input  wire logic                exc_return_i, // exception return restores state
    input  wire logic [7:0]          ret_state_i,  // state read from stacked status
    output logic                     in_block_o,   // a block is in progress
    output logic                     execute_o,    // issued instruction takes effect
    output logic [3:0]               slot_cond_o,  // condition of the current slot
    output logic [7:0]               state_o,      // live execution state
    output logic [7:0]               saved_state_o,// state captured at exception entry
    output logic                     misuse_o      // disallowed instruction in a block, or always if-then with an else slot
);
    import itb_pkg::*;

    // state layout: [7:4] slot condition, [3:0] mask; mask zero means outside a block
    logic [7:0] state_r;
    logic [7:0] state_nxt;
    logic [7:0] saved_r;
    logic       misuse_r;
    logic       misuse_nxt;

    wire [3:0] cur_cond = state_r[ITB_COND_LSB +: 4];
    wire [3:0] cur_mask = state_r[ITB_MASK_LSB +: 4];
    wire       active   = (cur_mask != 4'h0);
    wire       is_it    = (instr_i.cls == ITB_CLS_IF_THEN);
    wire       is_breakpoint_instruction  = (instr_i.cls == ITB_CLS_BREAKPOINT);
    wire       cond_ok;

    // slot condition evaluated against the flags
    itb_cond_eval u_eval (
        .cond_i  (cur_cond),
        .flags_i (flags_i),
        .pass_o  (cond_ok)
    );

    // last slot when only the terminating one bit remains
    wire       last_slot = (cur_mask[2:0] == 3'h0);
    // shift: next selector bit replaces the condition low bit
    wire [7:0] adv_state = last_slot ? ITB_STATE_RST
                                     : {cur_cond[3:1], cur_mask[3], cur_mask[2:0], 1'b0};
    // new block: selector mask with trailing one marks length 1..4
    wire [7:0] new_state = {instr_i.it_cond, instr_i.it_mask};

    // instructions that must not sit inside a block (software duty, flagged only)
    wire bad_cls = is_it | (instr_i.cls == ITB_CLS_CMP_BRANCH)
                 | (instr_i.cls == ITB_CLS_MASK_CHG);
    wire bad_pc  = (instr_i.cls == ITB_CLS_PC_WRITE) & ~last_slot;
    // always condition with an else selector: any mask one above the trailing one
    wire [3:0] mask_less = instr_i.it_mask - 4'h1;
    wire bad_al  = is_it & (instr_i.it_cond == ITB_COND_ALWAYS)
                 & ((instr_i.it_mask & mask_less) != 4'h0);

    // next-state selection; exception entry clears the live state for the handler, return wins over entry
    always_comb begin
        state_nxt  = state_r;
        misuse_nxt = misuse_r;
        if (exc_return_i) begin
            state_nxt = ret_state_i;
        end else if (exc_entry_i) begin
            state_nxt = ITB_STATE_RST;
        end else if (issue_i) begin
            if (active) begin
                state_nxt  = adv_state;
                misuse_nxt = misuse_r | bad_cls | bad_pc;
            end else if (is_it && instr_i.it_mask != 4'h0) begin
                state_nxt  = new_state;
                misuse_nxt = misuse_r | bad_al;
            end
        end
    end

    // state and capture registers; entry snapshot is what gets stacked
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r  <= ITB_STATE_RST;
            saved_r  <= ITB_STATE_RST;
            misuse_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            misuse_r <= misuse_nxt;
            if (exc_entry_i && !exc_return_i) begin
                saved_r <= state_r;
            end
        end
    end

    // outside a block all execute; breakpoint always executes
    // the always condition passes every slot, so then-only blocks run unconditionally
    assign execute_o     = ~active | cond_ok | is_breakpoint_instruction;
    assign in_block_o    = active;
    assign slot_cond_o   = active ? cur_cond : ITB_COND_ALWAYS;
    assign state_o       = state_r;
    assign saved_state_o = saved_r;
    assign misuse_o      = misuse_r;
endmodule : itb_core
`default_nettype wire

// File: dv/itb_checker.sv
// assertions on the if-then block tracker ports
`timescale 1ns/100ps
`default_nettype none
module itb_checker
    import itb_pkg::*;
(
    input wire logic                clock_i,      // core clock
    input wire logic                rst_i,        // async reset
    input wire logic                issue_i,      // completion strobe
    input wire itb_pkg::itb_instr_t instr_i,      // completing instr
    input wire logic                exc_entry_i,  // exception entry
    input wire logic                exc_return_i, // exception return
    input wire logic [7:0]          ret_state_i,  // stacked state
    input wire logic                in_block_o,   // block live
    input wire logic                execute_o,    // takes effect
    input wire logic [3:0]          slot_cond_o,  // slot condition
    input wire logic [7:0]          state_o,      // live state
    input wire logic [7:0]          saved_state_o // entry snapshot
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // nested if-then is only flagged as misuse; it is kept out of the advance steps
    sequence s_clean; issue_i && !exc_entry_i && !exc_return_i; endsequence
    sequence s_step; s_clean ##0 in_block_o && instr_i.cls != ITB_CLS_IF_THEN; endsequence
    a_idle_slot: assert property (!in_block_o |-> execute_o && slot_cond_o == ITB_COND_ALWAYS)
        else $error("idle slot");
    a_block_open: assert property (s_clean ##0 !in_block_o && instr_i.cls == ITB_CLS_IF_THEN && instr_i.it_mask != 4'h0
        |=> state_o == {$past(instr_i.it_cond), $past(instr_i.it_mask)}) else $error("open");
    a_slot_cond: assert property (in_block_o |-> slot_cond_o == state_o[7:4]) else $error("slot");
    a_slot_advance: assert property (s_step ##0 state_o[2:0] != 3'h0
        |=> state_o == {$past(state_o[7:5]), $past(state_o[3:0]), 1'b0}) else $error("advance");
    a_block_end: assert property (s_step ##0 state_o[2:0] == 3'h0 |=> state_o == 8'h00) else $error("end");
    a_breakpoint_instruction_runs: assert property (issue_i && instr_i.cls == ITB_CLS_BREAKPOINT |-> execute_o) else $error("breakpoint_instruction");
    a_exc_save: assert property (exc_entry_i && !exc_return_i |=> saved_state_o == $past(state_o) && !in_block_o)
        else $error("save");
    a_exc_resume: assert property (exc_return_i |=> state_o == $past(ret_state_i)) else $error("resume");
endmodule : itb_checker
bind itb_core itb_checker itb_checker_inst (.clock_i, .rst_i, .issue_i, .instr_i, .exc_entry_i, .exc_return_i,
    .ret_state_i, .in_block_o, .execute_o, .slot_cond_o, .state_o, .saved_state_o);
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the if-then block tracker
`timescale 1ns/100ps
`default_nettype none
module tb;
    import itb_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0, exc_entry_i = 1'b0, exc_return_i = 1'b0;
    logic [7:0] ret_state_i = 8'h00, state_o, saved_state_o;
    itb_instr_t instr_i = '0;
    itb_flags_t flags_i = 4'h4; // zero set: equal holds, not-equal fails
    logic in_block_o, execute_o, misuse_o;
    logic [3:0] slot_cond_o;
    int bad_count = 0, total_checks = 0;
    always #20 clock_i = ~clock_i;
    itb_core itb_core_inst (.clock_i, .rst_i, .issue_i, .instr_i, .flags_i, .exc_entry_i, .exc_return_i,
        .ret_state_i, .in_block_o, .execute_o, .slot_cond_o, .state_o, .saved_state_o, .misuse_o);
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (!ok) bad_count++;
        if (!ok) $display("[ERR] %0t %s", $time, msg);
    endtask : chk
    // execute is combinational, so it is judged before the edge takes the instruction
    task automatic step(input itb_cls_t c, input logic [7:0] cm, input logic ex);
        issue_i = 1'b1;
        instr_i = {c, cm};
        #1 chk(execute_o === ex, "execute");
        @(posedge clock_i) #1;
    endtask : step
    // equal, then-then-else-else: a failing plain slot and a failing breakpoint slot
    task automatic t_slots();
        step(ITB_CLS_IF_THEN, 8'h07, 1'b1);
        chk(state_o === 8'h07, "open");
        for (int k = 0; k < 4; k++) begin
            chk(slot_cond_o === {3'h0, k[1]}, "slot");
            step(k == 3 ? ITB_CLS_BREAKPOINT : ITB_CLS_PLAIN, 8'h00, k != 2);
            chk(state_o === 8'(32'h0E1C1800 >> (24 - 8 * k)), "advance");
        end
    endtask : t_slots
    task automatic t_exc();
        step(ITB_CLS_IF_THEN, 8'h1F, 1'b1);
        step(ITB_CLS_PLAIN, 8'h00, 1'b0);
        issue_i = 1'b0;
        exc_entry_i = 1'b1;
        ret_state_i = 8'h1E;
        @(posedge clock_i) #1;
        exc_entry_i = 1'b0;
        exc_return_i = 1'b1;
        chk(saved_state_o === 8'h1E && state_o === 8'h00, "save");
        @(posedge clock_i) #1;
        exc_return_i = 1'b0;
        chk(state_o === 8'h1E && slot_cond_o === 4'h1, "resume");
        step(ITB_CLS_PLAIN, 8'h00, 1'b0);
        step(ITB_CLS_PLAIN, 8'h00, 1'b0);
        step(ITB_CLS_PC_WRITE, 8'h00, 1'b0);
        chk(misuse_o === 1'b0 && state_o === 8'h00, "pc last");
    endtask : t_exc
    // a nested if-then is flagged; only reset clears the sticky flag
    task automatic t_refuse();
        step(ITB_CLS_IF_THEN, 8'hE8, 1'b1);
        step(ITB_CLS_IF_THEN, 8'h08, 1'b1);
        chk(misuse_o === 1'b1, "misuse");
        issue_i = 1'b0;
        rst_i = 1'b1;
        @(posedge clock_i) #1;
        rst_i = 1'b0;
        chk(misuse_o === 1'b0 && state_o === 8'h00, "reset");
    endtask : t_refuse
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (8) @(posedge clock_i);
        #1 rst_i = 1'b0;
        t_slots();
        t_exc();
        t_refuse();
        give_verdict();
    end
    // the run needs well under 50 cycles
    initial begin
        #20000 bad_count++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
